/* plq_pkg.sv */
package plq_pkg;
    // ****************************************
    // Qualification counts
    // ****************************************
    localparam int unsigned N_ACQ_CYCLES   = 32;
    localparam int unsigned N_TRK_CYCLES   = 128;
    localparam int unsigned CNT_W          = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
    localparam logic [CNT_W-1:0] ACQ_LAST  = CNT_W'(N_ACQ_CYCLES - 1);
    localparam logic [CNT_W-1:0] TRK_LAST  = CNT_W'(N_TRK_CYCLES - 1);
    localparam logic RST_FLAG              = 1'b0;

    // ****************************************
    // Qualification states
    // ****************************************
    typedef enum logic [1:0] {
        PLQ_OFF   = 2'b00,
        PLQ_ACQ   = 2'b01,
        PLQ_TRK   = 2'b11,
        PLQ_LOCK  = 2'b10
    } plq_state_t;
endpackage

/* plq_win_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface plq_win_if;
    // ****************************************
    // Window counter control and result
    // ****************************************
    logic tick;
    logic in_tol;
    logic clear;
    logic [7:0] last;
    logic done;
    modport ctrl (output tick, output in_tol, output clear, output last, input done);
    modport cnt  (input tick, input in_tol, input clear, input last, output done);
endinterface
`default_nettype wire

/* plq_win_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module plq_win_cnt
    import plq_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    plq_win_if.cnt    win
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             done_reg;
    logic             done_next;

    // ****************************************
    // Window count over reference periods
    // ****************************************
    always_comb begin
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (win.clear) begin
            cnt_next = CNT_ZERO;
        end else if (win.tick) begin
            if (!win.in_tol) begin
                cnt_next = CNT_ZERO;
            end else if (cnt_reg == win.last) begin
                cnt_next  = CNT_ZERO;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cnt_reg  <= CNT_ZERO;
            done_reg <= RST_FLAG;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign win.done = done_reg;
endmodule
`default_nettype wire

/* plq_top.sv */
// Behaviour
// - In automatic mode, lock-done status bit sets when lock interval ends.
// - Intervals count whole reference periods and end on a period boundary.
// - Leave acquisition after a fixed count of in-tolerance reference cycles.
// - Declare lock after a second fixed count within lock tolerance.
// - Tolerance is judged on every reference period; one out-of-tolerance period restarts the window.
// - Order after enable: acquisition, then tracking, then lock-done.
// - In automatic mode, acquisition-done bit sets when acquisition ends.
// - In automatic mode, every lock-done change sets event flag; request only when enabled.
// - Outside automatic mode requests are suppressed and event flag reads zero.
// - Halved VCO base clock selection is accepted even while unlocked.
`timescale 1ns/1ps
`default_nettype none
module plq_top
    import plq_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic pll_on_in,
    input  wire logic auto_mode_in,
    input  wire logic ref_tick_in,
    input  wire logic trk_tol_in,
    input  wire logic lock_tol_in,
    input  wire logic pll_interrupt_enable_in,
    input  wire logic event_flag_clr_in,
    input  wire logic base_clock_select_in,
    output logic      acq_done_out,
    output logic      lock_done_out,
    output logic      tracking_out,
    output logic      pll_event_flag_out,
    output logic      pll_irq_out,
    output logic      base_clock_select_out
);
    plq_state_t       state_reg;
    plq_state_t       state_next;
    logic             acq_reg;
    logic             acq_next;
    logic             lock_reg;
    logic             lock_next;
    logic             trk_reg;
    logic             trk_next;
    logic             flag_reg;
    logic             flag_next;
    logic             bcs_reg;
    logic             bcs_next;
    logic             run_en;
    logic             lock_lost;
    logic             lock_edge;

    plq_win_if win ();

    // ****************************************
    // Helper decodes
    // ****************************************
    function automatic logic in_acq(input plq_state_t st);
        return st == PLQ_ACQ;
    endfunction

    function automatic logic win_idle(input plq_state_t st);
        return (st == PLQ_OFF) || (st == PLQ_LOCK);
    endfunction

    // ****************************************
    // Window counter
    // ****************************************
    plq_win_cnt u_win (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .win        (win)
    );

    // ****************************************
    // Qualification enable
    // ****************************************
    assign run_en = pll_on_in && auto_mode_in;

    // ****************************************
    // Lock loss detect
    // ****************************************
    assign lock_lost = (state_reg == PLQ_LOCK) && ref_tick_in && !lock_tol_in;

    // ****************************************
    // Window control
    // ****************************************
    always_comb begin
        win.tick  = ref_tick_in;
        win.clear = !run_en || win_idle(state_reg);
        if (in_acq(state_reg)) begin
            win.in_tol = trk_tol_in;
            win.last   = ACQ_LAST;
        end else begin
            win.in_tol = lock_tol_in;
            win.last   = TRK_LAST;
        end
    end

    // ****************************************
    // Qualification sequence
    // ****************************************
    always_comb begin
        state_next = state_reg;
        acq_next   = acq_reg;
        lock_next  = lock_reg;
        if (!run_en) begin
            state_next = PLQ_OFF;
            acq_next   = 1'b0;
            lock_next  = 1'b0;
        end else begin
            case (state_reg)
                PLQ_OFF: begin
                    state_next = PLQ_ACQ;
                end
                PLQ_ACQ: begin
                    if (win.done) begin
                        state_next = PLQ_TRK;
                        acq_next   = 1'b1;
                    end
                end
                PLQ_TRK: begin
                    if (win.done) begin
                        state_next = PLQ_LOCK;
                        lock_next  = 1'b1;
                    end
                end
                PLQ_LOCK: begin
                    if (lock_lost) begin
                        state_next = PLQ_TRK;
                        lock_next  = 1'b0;
                    end
                end
                default: begin
                    state_next = PLQ_OFF;
                    acq_next   = 1'b0;
                    lock_next  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= PLQ_OFF;
            acq_reg   <= RST_FLAG;
            lock_reg  <= RST_FLAG;
        end else begin
            state_reg <= state_next;
            acq_reg   <= acq_next;
            lock_reg  <= lock_next;
        end
    end

    // ****************************************
    // Tracking status
    // ****************************************
    always_comb begin
        trk_next = (state_next == PLQ_TRK) || (state_next == PLQ_LOCK);
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            trk_reg <= RST_FLAG;
        end else begin
            trk_reg <= trk_next;
        end
    end

    // ****************************************
    // Event flag
    // ****************************************
    assign lock_edge = lock_next != lock_reg;

    always_comb begin
        flag_next = flag_reg;
        if (event_flag_clr_in) begin
            flag_next = 1'b0;
        end
        if (lock_edge) begin
            flag_next = 1'b1;
        end
        if (!auto_mode_in) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flag_reg <= RST_FLAG;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ****************************************
    // Base clock select
    // ****************************************
    always_comb begin
        bcs_next = base_clock_select_in && pll_on_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            bcs_reg <= RST_FLAG;
        end else begin
            bcs_reg <= bcs_next;
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    assign acq_done_out          = acq_reg;
    assign lock_done_out         = lock_reg;
    assign tracking_out          = trk_reg;

    // ****************************************
    // Event and clock outputs
    // ****************************************
    assign pll_event_flag_out    = flag_reg && auto_mode_in;
    assign pll_irq_out           = flag_reg && auto_mode_in && pll_interrupt_enable_in;
    assign base_clock_select_out = bcs_reg;
endmodule
`default_nettype wire

/* plq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module plq_checker (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic pll_on_in,
    input wire logic auto_mode_in,
    input wire logic ref_tick_in,
    input wire logic acq_done_out,
    input wire logic lock_done_out,
    input wire logic pll_event_flag_out,
    input wire logic pll_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_off; !auto_mode_in |-> !pll_event_flag_out; endproperty
    a_off: assert property (p_off) else $error("flag");
    property p_irq; pll_irq_out |-> pll_event_flag_out && auto_mode_in; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_ord; lock_done_out |-> acq_done_out; endproperty
    a_ord: assert property (p_ord) else $error("order");
    property p_acq; $rose(acq_done_out) |-> $past(ref_tick_in, 2); endproperty
    a_acq: assert property (p_acq) else $error("acq");
    property p_lck; $rose(lock_done_out) |-> $past(ref_tick_in, 2); endproperty
    a_lck: assert property (p_lck) else $error("lock");
    property p_chg; $changed(lock_done_out) && auto_mode_in |-> pll_event_flag_out; endproperty
    a_chg: assert property (p_chg) else $error("event");
    property p_hold; acq_done_out |=> acq_done_out || !pll_on_in || !auto_mode_in; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_drop; !pll_on_in |=> !acq_done_out && !lock_done_out; endproperty
    a_drop: assert property (p_drop) else $error("drop");
    c_acq: cover property ($rose(acq_done_out));
    c_lck: cover property ($rose(lock_done_out));
    c_irq: cover property ($rose(pll_irq_out));
endmodule
bind plq_top plq_checker i_plq_checker (.*);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in = 1'h0, sys_rst_in = 1'h1, pll_on_in = 1'h0, auto_mode_in = 1'h0, ref_tick_in = 1'h0;
    logic trk_tol_in = 1'h0, lock_tol_in = 1'h0, event_flag_clr_in = 1'h0, base_clock_select_in = 1'h0;
    logic pll_interrupt_enable_in = 1'h1;
    wire acq_done_out, lock_done_out, tracking_out, pll_event_flag_out, pll_irq_out, base_clock_select_out;
    int n_mismatch = 0, n_compared = 0, n_cyc = 0;
    plq_top i_plq_top (.*);
    initial forever #50 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (++n_cyc == 4000) complete_run(1);
    task chk(input logic s, input logic e);
        n_compared++;
        n_mismatch += int'(s !== e);
        if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
    endtask
    task complete_run(input int x);
        n_mismatch += x;
        $display("compared %0d mismatch %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task tick(input int n, input logic t);
        repeat (n) begin
            @(posedge ref_clk_in);
            ref_tick_in <= 1'h1;
            trk_tol_in <= t;
            lock_tol_in <= t;
            event_flag_clr_in <= 1'h0;
            @(posedge ref_clk_in);
            ref_tick_in <= 1'h0;
        end
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    task t_qual();
        pll_on_in <= 1'h1;
        auto_mode_in <= 1'h1;
        tick(31, 1'h1);
        tick(1, 1'h0);
        tick(31, 1'h1);
        chk(acq_done_out, 1'h0);
        chk(tracking_out, 1'h0);
        tick(1, 1'h1);
        chk(acq_done_out, 1'h1);
        chk(tracking_out, 1'h1);
        chk(lock_done_out, 1'h0);
        tick(127, 1'h1);
        chk(lock_done_out, 1'h0);
        tick(1, 1'h1);
        chk(lock_done_out, 1'h1);
        chk(pll_irq_out, 1'h1);
    endtask
    task t_loss();
        @(posedge ref_clk_in);
        event_flag_clr_in <= 1'h1;
        pll_interrupt_enable_in <= 1'h0;
        tick(1, 1'h0);
        chk(lock_done_out, 1'h0);
        chk(pll_event_flag_out, 1'h1);
        chk(pll_irq_out, 1'h0);
        @(posedge ref_clk_in);
        auto_mode_in <= 1'h0;
        pll_interrupt_enable_in <= 1'h1;
        repeat (8) @(posedge ref_clk_in);
        base_clock_select_in <= 1'h1;
        tick(0, 1'h0);
        chk(pll_event_flag_out, 1'h0);
        chk(pll_irq_out, 1'h0);
        chk(base_clock_select_out, 1'h1);
        @(posedge ref_clk_in);
        pll_on_in <= 1'h0;
        tick(0, 1'h0);
        chk(base_clock_select_out, 1'h0);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'h0;
        t_qual();
        t_loss();
        complete_run(0);
    end
endmodule
`default_nettype wire
